// ### src/otwc_top.v
// Overtemperature warning comparator: threshold register, compare and debounced flag
`timescale 1ns/1ps
`include "otwc_regs.vh"

// Function
// - Warning needs 100 ms continuous below-threshold
// - Threshold is code with zero MSB
// - Compare only nine MSBs of reading
// - Warn when reading strictly below threshold
// - Code maps linearly, 3.125 mV per step
module otwc_top #(
    parameter integer ADC_W           = 12,
    parameter integer DEBOUNCE_CYCLES = `OTWC_DEBOUNCE_CYCLES,
    parameter integer CNT_W           = 23,
    parameter [7:0]   THR_RESET       = `OTWC_WARN_THR_RESET
) (
    input  wire                       sys_clk_i,
    input  wire                       sys_rst_i,
    // Register port
    input  wire                       reg_wr_i,
    input  wire                       reg_rd_i,
    input  wire [`OTWC_ADDR_W-1:0]    reg_addr_i,
    input  wire [`OTWC_WARN_THR_W-1:0] reg_wdata_i,
    output reg  [`OTWC_WARN_THR_W-1:0] reg_rdata_o,
    output reg                        reg_rd_hit_o,
    // Temperature-sense ADC result
    input  wire                       adc_valid_i,
    input  wire [ADC_W-1:0]           adc_data_i,
    // Status
    output wire                       overtemperature_warning_o,
    output wire                       below_threshold_o,
    output wire                       thr_code_illegal_o,
    output wire [`OTWC_CMP_W-1:0]     reading_msbs_o
);

    // =====================================================================
    // Helper functions

    // Zero-extended threshold compared against truncated reading
    function cmp_below;
        input [`OTWC_CMP_W-1:0]      reading;
        input [`OTWC_WARN_THR_W-1:0] code;
        begin
            cmp_below = (reading < {1'b0, code});
        end
    endfunction

    // Codes outside the supported window are out of spec for software
    function code_illegal;
        input [`OTWC_WARN_THR_W-1:0] code;
        begin
            code_illegal = (code < `OTWC_THR_CODE_MIN) || (code > `OTWC_THR_CODE_MAX);
        end
    endfunction

    // =====================================================================
    // State encoding
    localparam [2:0] ST_IDLE    = 3'b001;
    localparam [2:0] ST_QUALIFY = 3'b010;
    localparam [2:0] ST_WARN    = 3'b100;

    // =====================================================================
    // Storage
    reg  [`OTWC_WARN_THR_W-1:0] thr_reg;
    reg  [`OTWC_WARN_THR_W-1:0] thr_next;
    reg  [`OTWC_CMP_W-1:0]      reading_reg;
    reg  [`OTWC_CMP_W-1:0]      reading_next;
    reg                         reading_seen_reg;
    reg  [2:0]                  state_reg;
    reg  [2:0]                  state_next;
    reg                         warn_reg;
    reg                         below_reg;
    reg                         illegal_reg;

    wire                        addr_hit;
    wire                        below_now;
    wire                        qualified;

    // =====================================================================
    // Register port decode
    assign addr_hit = (reg_addr_i == `OTWC_WARN_THR_ADDR);

    // linear code, no remap
    // The code is stored and used as written; its weight in millivolts
    // is fixed by the ADC scaling, so no conversion lives here.
    always @* begin
        thr_next = thr_reg;
        if (reg_wr_i) begin
            if (addr_hit) begin
                thr_next = reg_wdata_i;
            end
        end
    end

    // Threshold register; writes to other addresses are ignored
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            thr_reg <= THR_RESET;
        end else begin
            thr_reg <= thr_next;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero, hit low
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= {`OTWC_WARN_THR_W{1'b0}};
            reg_rd_hit_o <= 1'b0;
        end else if (reg_rd_i) begin
            if (addr_hit) begin
                reg_rdata_o  <= thr_reg;
                reg_rd_hit_o <= 1'b1;
            end else begin
                reg_rdata_o  <= {`OTWC_WARN_THR_W{1'b0}};
                reg_rd_hit_o <= 1'b0;
            end
        end else begin
            reg_rd_hit_o <= 1'b0;
        end
    end

    // =====================================================================
    // Reading capture

    // keep nine MSBs
    // Lower bits carry noise finer than a threshold step, so drop them
    always @* begin
        reading_next = reading_reg;
        if (adc_valid_i) begin
            reading_next = adc_data_i[ADC_W-1 -: `OTWC_CMP_W];
        end
    end

    // Hold last reading; compare stays off until a first sample arrives
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reading_reg      <= {`OTWC_CMP_W{1'b0}};
            reading_seen_reg <= 1'b0;
        end else begin
            reading_reg <= reading_next;
            if (adc_valid_i) begin
                reading_seen_reg <= 1'b1;
            end
        end
    end

    assign below_now = reading_seen_reg && cmp_below(reading_reg, thr_reg);

    // =====================================================================
    // Debounce counter
    otwc_debounce #(
        .CYCLES (DEBOUNCE_CYCLES),
        .CNT_W  (CNT_W)
    ) u_debounce (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .cond_i      (below_now),
        .qualified_o (qualified),
        .count_o     ()
    );

    // =====================================================================
    // Warning state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (below_now) begin
                    state_next = ST_QUALIFY;
                end
            end
            ST_QUALIFY: begin
                if (!below_now) begin
                    state_next = ST_IDLE;
                end else if (qualified) begin
                    state_next = ST_WARN;
                end
            end
            ST_WARN: begin
                // Flag drops as soon as the reading recovers
                if (!below_now) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State and registered status outputs
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_reg   <= ST_IDLE;
            warn_reg    <= 1'b0;
            below_reg   <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            warn_reg    <= (state_next == ST_WARN);
            below_reg   <= below_now;
            illegal_reg <= code_illegal(thr_next);
        end
    end

    // =====================================================================
    // Outputs
    assign overtemperature_warning_o = warn_reg;
    assign below_threshold_o         = below_reg;
    assign thr_code_illegal_o        = illegal_reg;
    assign reading_msbs_o            = reading_reg;

endmodule

// ### src/otwc_regs.vh
// Register offsets, field layout, reset values and timing counts of the warning comparator
`ifndef OTWC_REGS_VH
`define OTWC_REGS_VH

// =====================================================================
// Register map
`define OTWC_ADDR_W            16
`define OTWC_WARN_THR_ADDR     16'hfe1a
`define OTWC_WARN_THR_W        8
`define OTWC_WARN_THR_RESET    8'h03

// =====================================================================
// Threshold field and legal code window
`define OTWC_CMP_W             9
`define OTWC_THR_CODE_MIN      8'h03
`define OTWC_THR_CODE_MAX      8'hfa
`define OTWC_THR_STEPS         256
`define OTWC_THR_FULL_UV       800000
`define OTWC_THR_STEP_UV       3125

// =====================================================================
// Debounce timing
`define OTWC_DEBOUNCE_MS       100
`define OTWC_CLK_HZ            50000000
`define OTWC_DEBOUNCE_CYCLES   (`OTWC_DEBOUNCE_MS * (`OTWC_CLK_HZ / 1000))

`endif

// ### src/otwc_debounce.v
// Persistence counter that qualifies a condition held for a set number of cycles
`timescale 1ns/1ps

module otwc_debounce #(
    parameter integer CYCLES = 5000000,
    parameter integer CNT_W  = 23
) (
    input  wire             sys_clk_i,
    input  wire             sys_rst_i,
    input  wire             cond_i,
    output wire             qualified_o,
    output wire [CNT_W-1:0] count_o
);

    // Last count value, cut on purpose to the counter width
    localparam integer     LAST_INT = CYCLES - 1;
    localparam [CNT_W-1:0] LAST     = LAST_INT[CNT_W-1:0];

    reg  [CNT_W-1:0] count_reg;
    reg  [CNT_W-1:0] count_next;

    // Condition has held for the full interval on this cycle
    assign qualified_o = cond_i && (count_reg == LAST);
    assign count_o     = count_reg;

    // restart on drop
    // Saturate at the last value so a long hold never wraps into a false restart
    always @* begin
        count_next = count_reg;
        if (!cond_i) begin
            count_next = {CNT_W{1'b0}};
        end else if (count_reg != LAST) begin
            count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_reg <= {CNT_W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// ### verif/otwc_adc_model.sv
// Behavioural temperature-sense converter feeding the warning comparator
`timescale 1ns/1ps
module otwc_adc_model (
    input  wire logic        sys_clk_i,
    input  wire logic [1:0]  gap_i,
    input  wire logic [8:0]  level_i,
    output logic             adc_valid_o,
    output logic [11:0]      adc_data_o
);
    logic [1:0]  wait_reg  = 2'h0;
    logic [2:0]  lsb_reg   = 3'h0;
    logic        valid_reg = 1'b0;
    logic [11:0] data_reg  = 12'h000;
    // =========
    // Sampling
    assign adc_valid_o = valid_reg;
    assign adc_data_o  = data_reg;
    // One sample every gap_i+1 cycles; the bus toggles between samples so stale data never looks valid
    always @(posedge sys_clk_i) begin
        lsb_reg <= lsb_reg + 3'h5;
        if (wait_reg >= gap_i) begin
            wait_reg  <= 2'h0;
            valid_reg <= 1'b1;
            data_reg  <= {level_i, lsb_reg};
        end else begin
            wait_reg  <= wait_reg + 2'h1;
            valid_reg <= 1'b0;
            data_reg  <= ~data_reg;
        end
    end
endmodule

// ### verif/otwc_top_sva.sv
// Port checker for the warning comparator
`timescale 1ns/1ps
module otwc_top_sva #(
    parameter integer ADC_W           = 12,
    parameter integer DEBOUNCE_CYCLES = 16
) (
    input logic             sys_clk_i,
    input logic             sys_rst_i,
    input logic             reg_wr_i,
    input logic             reg_rd_i,
    input logic [15:0]      reg_addr_i,
    input logic [7:0]       reg_wdata_i,
    input logic [7:0]       reg_rdata_o,
    input logic             reg_rd_hit_o,
    input logic             adc_valid_i,
    input logic [ADC_W-1:0] adc_data_i,
    input logic             overtemperature_warning_o,
    input logic             below_threshold_o,
    input logic             thr_code_illegal_o,
    input logic [8:0]       reading_msbs_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] thr_reg;
    logic       seen_reg;
    int         run_reg;
    // =========
    // Shadow threshold and run length of the raw compare
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            thr_reg  <= 8'h03;
            seen_reg <= 1'b0;
            run_reg  <= 0;
        end else begin
            if (reg_wr_i && reg_addr_i == 16'hfe1a)
                thr_reg <= reg_wdata_i;
            seen_reg <= seen_reg | adc_valid_i;
            run_reg  <= below_threshold_o ? run_reg + 1 : 0;
        end
    end
    sequence s_recover;
        $fell(below_threshold_o);
    endsequence
    a_warn_not_early: assert property ($rose(overtemperature_warning_o) |->
        run_reg == DEBOUNCE_CYCLES - 1 && below_threshold_o)
        else $error("warning rose off the debounce count");
    a_warn_not_late: assert property (run_reg >= DEBOUNCE_CYCLES - 1 && below_threshold_o |->
        overtemperature_warning_o) else $error("warning missing after long run");
    a_warn_clears: assert property (s_recover |-> !overtemperature_warning_o)
        else $error("warning stayed after recovery");
    a_cmp_strict: assert property (seen_reg |=> below_threshold_o ==
        ($past(reading_msbs_o) < {1'b0, $past(thr_reg)})) else $error("compare wrong");
    a_cap_msbs: assert property (adc_valid_i |=>
        reading_msbs_o == $past(adc_data_i[ADC_W-1 -: 9])) else $error("capture wrong");
    a_rd_hit: assert property (reg_rd_i && reg_addr_i == 16'hfe1a |=>
        reg_rd_hit_o && reg_rdata_o == $past(thr_reg)) else $error("read back wrong");
    a_rd_miss: assert property (reg_rd_i && reg_addr_i != 16'hfe1a |=>
        !reg_rd_hit_o && reg_rdata_o == 8'h00) else $error("unmapped read wrong");
    a_code_legal: assert property (reg_wr_i && reg_addr_i == 16'hfe1a |=>
        thr_code_illegal_o == ($past(reg_wdata_i) < 8'h03 || $past(reg_wdata_i) > 8'hfa))
        else $error("illegal flag wrong");
endmodule
bind otwc_top otwc_top_sva #(.ADC_W(ADC_W), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) otwc_top_sva_i (.*);

// ### verif/otwc_top_tb_top.sv
// Self-checking bench for the warning comparator
`timescale 1ns/1ps
module otwc_top_tb_top;
    localparam integer N = 16;
    logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0]  reg_wdata_i = 8'h00, code;
    logic [1:0]  gap = 2'h0;
    logic [8:0]  level = 9'h1ff, v;
    logic        adc_valid, hit, warn, below, ill;
    logic [11:0] adc_data;
    logic [7:0]  rdata;
    logic [8:0]  msbs;
    logic [7:0]  corner [0:7] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'hf9, 8'hfa, 8'hfb, 8'hff};
    integer      miscompares = 0, num_checks = 0, seed = 32'h7e6d, i;
    otwc_top #(.DEBOUNCE_CYCLES(N), .CNT_W(5)) otwc_top_i (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata), .reg_rd_hit_o(hit),
        .adc_valid_i(adc_valid), .adc_data_i(adc_data), .overtemperature_warning_o(warn),
        .below_threshold_o(below), .thr_code_illegal_o(ill), .reading_msbs_o(msbs));
    otwc_adc_model otwc_adc_model_i (.sys_clk_i(sys_clk_i), .gap_i(gap), .level_i(level),
        .adc_valid_o(adc_valid), .adc_data_o(adc_data));
    // =========
    // Helpers
    function automatic logic exp_below(input logic [8:0] r, input logic [7:0] t);
        return r < {1'b0, t};
    endfunction
    function automatic logic exp_ill(input logic [7:0] t);
        return t < 8'h03 || t > 8'hfa;
    endfunction
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read answer is registered, so it is looked at just after the taking edge
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic h);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rdata", {1'b0, exp}, {1'b0, rdata});
        chk("hit", {8'h00, h}, {8'h00, hit});
    endtask
    task automatic hold(input logic [8:0] r, input integer n);
        @(posedge sys_clk_i);
        level <= r;
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic final_report;
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // =========
    // Clock, watchdog and main sequence
    initial forever #10 sys_clk_i = ~sys_clk_i;
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(16'hfe1a, 8'h03, 1'b1);
        wr(16'hfe19, 8'h55);
        rd(16'hfe19, 8'h00, 1'b0);
        for (i = 0; i < 40; i++) begin
            code = (i < 8) ? corner[i] : 8'($random(seed));
            gap <= 2'($random(seed));
            wr(16'hfe1a, code);
            rd(16'hfe1a, code, 1'b1);
            chk("illegal", {8'h00, exp_ill(code)}, {8'h00, ill});
            v = (i % 3 == 0) ? {1'b0, code} : (i % 3 == 1) ? {1'b0, code} - 9'h001
                : 9'($random(seed));
            hold(v, 8);
            chk("reading", v, msbs);
            chk("below", {8'h00, exp_below(v, code)}, {8'h00, below});
        end
        gap <= 2'h0;
        wr(16'hfe1a, 8'h80);
        hold(9'h1ff, 6);
        hold(9'h010, N - 4);
        chk("warn early", 9'h000, {8'h00, warn});
        hold(9'h080, 3);
        hold(9'h07f, N - 4);
        chk("warn restart", 9'h000, {8'h00, warn});
        hold(9'h07f, 14);
        chk("warn set", 9'h001, {8'h00, warn});
        hold(9'h080, 6);
        chk("warn clear", 9'h000, {8'h00, warn});
        final_report;
    end
endmodule
